// ### rtl/sfmr_array_mem.sv
// Purpose: Byte array of the flash with one registered read port.
// Assumes: One read or one load per core clock.
// Notes:   The load port stands in for programming, outside this block.
`timescale 1ns/1ps
module sfmr_array_mem #(
  parameter int AW = 21
) (
  // Clocking.
  input  wire logic          core_clk,
  input  wire logic          ce,
  // Read port.
  input  wire logic          rdEn,
  input  wire logic [AW-1:0] rdAddr,
  output logic      [7:0]    rdData,
  // Load port.
  input  wire logic          loadEn,
  input  wire logic [AW-1:0] loadAddr,
  input  wire logic [7:0]    loadData
);

  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge core_clk) begin
    if (ce) begin
      if (loadEn) begin
        mem[loadAddr] <= loadData;
      end
      if (rdEn) begin
        rdData <= mem[rdAddr];
      end
    end
  end

endmodule : sfmr_array_mem

// ### rtl/sfmr_pkg.sv
// Purpose: Types of the multi-line serial flash read logic.
// Assumes: Compiled before the design modules.
// Notes:   States use Gray codes along the quad-I/O command path only.
package sfmr_pkg;

  typedef enum logic [2:0] {
    SFMR_IDLE   = 3'h0,
    SFMR_OPCODE = 3'h1,
    SFMR_ADDR   = 3'h3,
    SFMR_MODE   = 3'h2,
    SFMR_DUMMY  = 3'h6,
    SFMR_DATA   = 3'h7,
    SFMR_IGNORE = 3'h5
  } sfmr_state_t;

  typedef enum logic [1:0] {
    SFMR_CMD_DOUT = 2'h0,
    SFMR_CMD_DIO  = 2'h1,
    SFMR_CMD_QOUT = 2'h2,
    SFMR_CMD_QIO  = 2'h3
  } sfmr_cmd_t;

endpackage : sfmr_pkg

// ### rtl/sfmr_read_core.sv
// Purpose: Multi-line array read commands of a serial flash device.
// Assumes: Serial pins are oversampled; serial clock at most core_clk/8.
// Notes:   Data are fetched ahead into a two-entry buffer.
`timescale 1ns/1ps
`include "sfmr_regs.svh"
module sfmr_read_core
  import sfmr_pkg::*;
#(
  parameter int AW = 21
) (
  // Clock, reset and enable.
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  // Serial pins.
  input  wire logic          csPin_n,
  input  wire logic          sclkPin,
  input  wire logic [3:0]    ioIn,
  output logic      [3:0]    ioOut,
  output logic      [3:0]    ioOe,
  // Configuration and status.
  input  wire logic          quadEnableBit,
  output logic               contReadActive,
  output logic      [7:0]    contReadModeBits,
  output logic               readBusy,
  // Array load port.
  input  wire logic          loadEn,
  input  wire logic [AW-1:0] loadAddr,
  input  wire logic [7:0]    loadData
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic       csS1_n;
  logic       csS2_n;
  logic       sclkS1;
  logic       sclkS2;
  logic       sclkS3;
  logic [3:0] ioS1;
  logic [3:0] ioS2;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      csS1_n <= 1'b1;
      csS2_n <= 1'b1;
      sclkS1 <= 1'b0;
      sclkS2 <= 1'b0;
      sclkS3 <= 1'b0;
      ioS1   <= 4'h0;
      ioS2   <= 4'h0;
    end else if (ce) begin
      csS1_n <= csPin_n;
      csS2_n <= csS1_n;
      sclkS1 <= sclkPin;
      sclkS2 <= sclkS1;
      sclkS3 <= sclkS2;
      ioS1   <= ioIn;
      ioS2   <= ioS1;
    end
  end

  logic sclkRise;
  logic sclkFall;
  assign sclkRise = sclkS2 & ~sclkS3;
  assign sclkFall = ~sclkS2 & sclkS3;

  ////////////////////////////////////////////////////////////////////////////
  // Lane decoding.

  // Lanes used in a phase: opcode is always single line.
  function automatic logic [2:0] laneWidth(sfmr_cmd_t cmd, logic isData,
                                           sfmr_state_t st);
    logic [2:0] w;
    w = 3'h1;
    if (st == SFMR_OPCODE) begin
      w = 3'h1;
    end else if (cmd == SFMR_CMD_QIO) begin
      w = 3'h4;
    end else if (cmd == SFMR_CMD_DIO) begin
      w = 3'h2;
    end else if (isData) begin
      w = (cmd == SFMR_CMD_QOUT) ? 3'h4 : 3'h2;
    end
    return w;
  endfunction : laneWidth

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry data buffer between array and shifter.

  logic       fifoInVld;
  logic       fifoInRdy;
  logic [7:0] fifoInData;
  logic       fifoOutVld;
  logic       fifoOutRdy;
  logic [7:0] fifoOutData;
  logic       fifoFlush;
  logic [7:0] fifoMem_r [0:1];
  logic [7:0] fifoMem_nxt [0:1];
  logic       fifoWp_r;
  logic       fifoWp_nxt;
  logic       fifoRp_r;
  logic       fifoRp_nxt;
  logic [1:0] fifoCnt_r;
  logic [1:0] fifoCnt_nxt;

  assign fifoInRdy   = (fifoCnt_r != 2'h2);
  assign fifoOutVld  = (fifoCnt_r != 2'h0);
  assign fifoOutData = fifoMem_r[fifoRp_r];

  always_comb begin
    logic doPush;
    logic doPop;
    doPush = fifoInVld & fifoInRdy;
    doPop  = fifoOutRdy & fifoOutVld;
    fifoMem_nxt[0] = fifoMem_r[0];
    fifoMem_nxt[1] = fifoMem_r[1];
    fifoWp_nxt     = fifoWp_r;
    fifoRp_nxt     = fifoRp_r;
    fifoCnt_nxt    = fifoCnt_r;
    if (fifoFlush) begin
      fifoWp_nxt  = 1'b0;
      fifoRp_nxt  = 1'b0;
      fifoCnt_nxt = 2'h0;
    end else begin
      if (doPush) begin
        fifoMem_nxt[fifoWp_r] = fifoInData;
        fifoWp_nxt            = ~fifoWp_r;
      end
      if (doPop) begin
        fifoRp_nxt = ~fifoRp_r;
      end
      fifoCnt_nxt = fifoCnt_r + {1'b0, doPush} - {1'b0, doPop};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fifoMem_r[0] <= 8'h00;
      fifoMem_r[1] <= 8'h00;
      fifoWp_r     <= 1'b0;
      fifoRp_r     <= 1'b0;
      fifoCnt_r    <= 2'h0;
    end else if (ce) begin
      fifoMem_r[0] <= fifoMem_nxt[0];
      fifoMem_r[1] <= fifoMem_nxt[1];
      fifoWp_r     <= fifoWp_nxt;
      fifoRp_r     <= fifoRp_nxt;
      fifoCnt_r    <= fifoCnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array fetch engine.

  logic          fetchOn_r;
  logic [AW-1:0] fetchAddr_r;
  logic          pend_r;
  logic          memRdEn;

  // A read is only issued when the buffer can take its result.
  assign memRdEn   = fetchOn_r & ~pend_r & fifoInRdy & ~fifoFlush;
  assign fifoInVld = pend_r & ~fifoFlush;

  sfmr_array_mem #(
    .AW (AW)
  ) sfmr_array_mem_inst (
    .core_clk (core_clk),
    .ce       (ce),
    .rdEn     (memRdEn),
    .rdAddr   (fetchAddr_r),
    .rdData   (fifoInData),
    .loadEn   (loadEn),
    .loadAddr (loadAddr),
    .loadData (loadData)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer and output shifter.

  sfmr_state_t   state_r;
  sfmr_state_t   state_nxt;
  sfmr_cmd_t     cmd_r;
  sfmr_cmd_t     cmd_nxt;
  logic [4:0]    cnt_r;
  logic [4:0]    cnt_nxt;
  logic [23:0]   sh_r;
  logic [23:0]   sh_nxt;
  logic [7:0]    mode_r;
  logic [7:0]    mode_nxt;
  logic          contQuad_r;
  logic          contQuad_nxt;
  logic          fetchOn_nxt;
  logic [AW-1:0] fetchAddr_nxt;
  logic [7:0]    outSh_r;
  logic [7:0]    outSh_nxt;
  logic [1:0]    beat_r;
  logic [1:0]    beat_nxt;
  logic [3:0]    ioOut_r;
  logic [3:0]    ioOut_nxt;
  logic [3:0]    ioOe_r;
  logic [3:0]    ioOe_nxt;

  logic          contSel;
  assign contSel = (mode_r[5:4] == `SFMR_CONT_SEL); // R6 R8 R16

  always_comb begin
    logic [2:0]  w;
    logic [23:0] shIn;
    logic [4:0]  cntIn;
    logic [7:0]  byteNow;
    logic        lastBeat;
    w             = laneWidth(cmd_r, state_r == SFMR_DATA, state_r);
    shIn          = {sh_r[22:0], ioS2[0]};
    state_nxt     = state_r;
    cmd_nxt       = cmd_r;
    cnt_nxt       = cnt_r;
    sh_nxt        = sh_r;
    mode_nxt      = mode_r;
    contQuad_nxt  = contQuad_r;
    fetchOn_nxt   = fetchOn_r;
    fetchAddr_nxt = fetchAddr_r;
    outSh_nxt     = outSh_r;
    beat_nxt      = beat_r;
    ioOut_nxt     = ioOut_r;
    ioOe_nxt      = ioOe_r;
    fifoOutRdy    = 1'b0;
    fifoFlush     = 1'b0;
    byteNow       = outSh_r;
    lastBeat      = (w == 3'h4) ? (beat_r == 2'h1) : (beat_r == 2'h3);
    if (w == 3'h2) begin
      shIn = {sh_r[21:0], ioS2[1:0]};
    end else if (w == 3'h4) begin
      shIn = {sh_r[19:0], ioS2};
    end
    cntIn = cnt_r + {2'h0, w};
    // Same issue test as memRdEn minus the flush term driven here; a flush
    // reloads or abandons the address, so the extra step does no harm.
    if (fetchOn_r && !pend_r && fifoInRdy) begin
      fetchAddr_nxt = fetchAddr_r + {{(AW-1){1'b0}}, 1'b1}; // R3 R12
    end
    if (csS2_n) begin
      // Frame over: release lines at once, even mid-byte.
      state_nxt   = SFMR_IDLE; // R4
      ioOe_nxt    = 4'h0; // R4
      fetchOn_nxt = 1'b0;
      fifoFlush   = 1'b1;
      cnt_nxt     = 5'h00;
      beat_nxt    = 2'h0;
    end else begin
      unique case (state_r)
        SFMR_IDLE: begin
          cnt_nxt = 5'h00;
          if (contSel) begin
            // No opcode in this frame: address starts at once.
            state_nxt = SFMR_ADDR; // R6 R16
            cmd_nxt   = contQuad_r ? SFMR_CMD_QIO : SFMR_CMD_DIO;
          end else begin
            state_nxt = SFMR_OPCODE; // R7
          end
        end
        SFMR_OPCODE: if (sclkRise) begin
          sh_nxt  = shIn;
          cnt_nxt = cntIn;
          if (cntIn == `SFMR_OPCODE_BITS) begin
            cnt_nxt   = 5'h00;
            state_nxt = SFMR_ADDR;
            unique case (shIn[7:0])
              `SFMR_OP_DUAL_OUT: cmd_nxt = SFMR_CMD_DOUT; // R1
              `SFMR_OP_DUAL_IO:  cmd_nxt = SFMR_CMD_DIO; // R5
              `SFMR_OP_QUAD_OUT: cmd_nxt = SFMR_CMD_QOUT; // R11
              `SFMR_OP_QUAD_IO: begin
                cmd_nxt = SFMR_CMD_QIO; // R13
                if (!quadEnableBit) begin
                  state_nxt = SFMR_IGNORE; // R15
                end
              end
              `SFMR_OP_MODE_RESET: begin
                mode_nxt  = `SFMR_MODE_RST_VAL; // R10
                state_nxt = SFMR_IGNORE;
              end
              default: state_nxt = SFMR_IGNORE;
            endcase
          end
        end
        SFMR_ADDR: if (sclkRise) begin
          sh_nxt  = shIn;
          cnt_nxt = cntIn; // R17 R18
          if (cntIn == `SFMR_ADDR_BITS) begin
            cnt_nxt       = 5'h00;
            fetchAddr_nxt = shIn[AW-1:0]; // R12
            fetchOn_nxt   = 1'b1;
            fifoFlush     = 1'b1;
            state_nxt     = (cmd_r == SFMR_CMD_DIO || cmd_r == SFMR_CMD_QIO)
                            ? SFMR_MODE : SFMR_DUMMY;
          end
        end
        SFMR_MODE: if (sclkRise) begin
          sh_nxt  = shIn; // R20
          cnt_nxt = cntIn;
          if (cntIn == `SFMR_MODE_BITS) begin
            cnt_nxt      = 5'h00;
            mode_nxt     = shIn[7:0]; // R6 R7
            contQuad_nxt = (cmd_r == SFMR_CMD_QIO); // R16
            // Host has released its lines before the first data edge.
            state_nxt    = (cmd_r == SFMR_CMD_QIO) ? SFMR_DUMMY
                                                   : SFMR_DATA; // R5 R9
          end
        end
        SFMR_DUMMY: if (sclkRise) begin
          cnt_nxt = cntIn;
          if (cntIn == ((cmd_r == SFMR_CMD_QIO) ? `SFMR_QDUMMY_BITS
                                                : `SFMR_DUMMY_BITS)) begin
            cnt_nxt   = 5'h00;
            state_nxt = SFMR_DATA; // R1 R11 R13
          end
        end
        SFMR_DATA: if (sclkFall) begin
          if (beat_r == 2'h0) begin
            byteNow    = fifoOutData;
            fifoOutRdy = 1'b1;
          end
          if (w == 3'h4) begin
            ioOut_nxt = byteNow[7:4]; // R14
            ioOe_nxt  = 4'hf;
            outSh_nxt = {byteNow[3:0], 4'h0};
          end else begin
            ioOut_nxt = {2'h0, byteNow[7:6]}; // R2
            ioOe_nxt  = 4'h3;
            outSh_nxt = {byteNow[5:0], 2'h0};
          end
          beat_nxt = lastBeat ? 2'h0 : beat_r + 2'h1;
        end
        SFMR_IGNORE: begin
          ioOe_nxt = 4'h0;
        end
        default: state_nxt = SFMR_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r     <= SFMR_IDLE;
      cmd_r       <= SFMR_CMD_DOUT;
      cnt_r       <= 5'h00;
      sh_r        <= 24'h000000;
      mode_r      <= `SFMR_MODE_RST_VAL; // R19
      contQuad_r  <= 1'b0;
      fetchOn_r   <= 1'b0;
      fetchAddr_r <= '0;
      pend_r      <= 1'b0;
      outSh_r     <= 8'h00;
      beat_r      <= 2'h0;
      ioOut_r     <= 4'h0;
      ioOe_r      <= 4'h0;
    end else if (ce) begin
      state_r     <= state_nxt;
      cmd_r       <= cmd_nxt;
      cnt_r       <= cnt_nxt;
      sh_r        <= sh_nxt;
      mode_r      <= mode_nxt;
      contQuad_r  <= contQuad_nxt;
      fetchOn_r   <= fetchOn_nxt;
      fetchAddr_r <= fetchAddr_nxt;
      pend_r      <= memRdEn;
      outSh_r     <= outSh_nxt;
      beat_r      <= beat_nxt;
      ioOut_r     <= ioOut_nxt;
      ioOe_r      <= ioOe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign ioOut            = ioOut_r;
  assign ioOe             = ioOe_r;
  assign contReadActive   = contSel;
  assign contReadModeBits = mode_r;
  assign readBusy         = (state_r != SFMR_IDLE);

endmodule : sfmr_read_core

// ### rtl/sfmr_regs.svh
// Purpose: Constants of the multi-line serial flash read logic.
// Assumes: Included by sfmr_read_core only; the package and sfmr_array_mem do not include it.
// Notes:   Counts are in transferred bits, not in serial clocks.
//
// Functional notes
// R1 - Dual-output read: opcode 3Bh, three address bytes, one dummy byte.
// R2 - Dual reads drive two bits per clock, MSB first on data-out line.
// R3 - After the last array byte the read continues at address zero.
// R4 - Chip select high ends the read and releases all driven lines.
// R5 - Dual-I/O read: opcode BBh, address on two lines, one mode byte.
// R6 - Dual-I/O mode bits 5:4 equal 1,0: next frame needs no opcode.
// R7 - Other mode bits 5:4: next frame expects a full opcode.
// R8 - The lower nibble of the mode byte is ignored.
// R9 - Host releases its lines before the first data falling clock.
// R10 - Continuous-read-mode reset command clears all eight mode bits.
// R11 - Quad-output read: opcode 6Bh, address, dummy byte, data on four lines.
// R12 - Any start address; address advances by one per byte sent.
// R13 - Quad-I/O read: opcode EBh, address, mode byte, two dummy bytes.
// R14 - Quad-I/O data: bits 7..4 then 3..0, one byte per two clocks.
// R15 - Quad-I/O read runs only while the quad enable bit is set; the code checks it only on opcode EBh, not in opcode-less frames.
// R16 - Quad-I/O mode bits 5:4 equal 1,0: next frame skips the opcode.
// R17 - Dual-I/O: address 12 clocks, mode byte 4 clocks.
// R18 - Quad-I/O: address 6 clocks, mode byte 2 clocks.
// R19 - Continuous read mode is inactive after reset.
// R20 - Mode bits are sampled on rising serial clock edges.
`ifndef SFMR_REGS_SVH
`define SFMR_REGS_SVH

`define SFMR_OP_DUAL_OUT   8'h3b
`define SFMR_OP_DUAL_IO    8'hbb
`define SFMR_OP_QUAD_OUT   8'h6b
`define SFMR_OP_QUAD_IO    8'heb
`define SFMR_OP_MODE_RESET 8'hff

`define SFMR_OPCODE_BITS   5'h08
`define SFMR_ADDR_BITS     5'h18
`define SFMR_MODE_BITS     5'h08
`define SFMR_DUMMY_BITS    5'h08
`define SFMR_QDUMMY_BITS   5'h10

`define SFMR_MODE_RST_VAL  8'h00
`define SFMR_CONT_SEL      2'h2

`endif

// ### testbench/sfmr_read_core_properties.sv
// Purpose: Port checks of the serial flash read core.
// Assumes: Bound to every sfmr_read_core instance.
// Notes:   Serial half periods are assumed to last 5+ core clocks.
`timescale 1ns/1ps
module sfmr_core_props (
  // Clock and reset.
  input logic       core_clk,
  input logic       rst_n,
  // Serial pins.
  input logic       csPin_n,
  input logic       sclkPin,
  input logic [3:0] ioOut,
  input logic [3:0] ioOe,
  // Status.
  input logic       contReadActive,
  input logic [7:0] contReadModeBits,
  input logic       readBusy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  a_reset_quiet: assert property ($rose(rst_n) |-> ioOe == 4'h0
    && !readBusy && !contReadActive && contReadModeBits == 8'h00)
    else $error("outputs not cleared by reset");
  a_cs_release: assert property (csPin_n [*6] |-> ioOe == 4'h0)
    else $error("lines still driven after chip select rose");
  a_busy_idle: assert property (csPin_n [*6] |-> !readBusy)
    else $error("sequencer busy outside a frame");
  a_oe_legal: assert property (ioOe inside {4'h0, 4'h3, 4'hf})
    else $error("illegal output enable pattern");
  a_cont_flag: assert property ($stable(contReadModeBits) |->
    contReadActive == (contReadModeBits[5:4] == 2'b10))
    else $error("continuous flag disagrees with mode bits");
  a_mode_frame: assert property (csPin_n [*6] |=>
    $stable(contReadModeBits))
    else $error("mode bits changed outside a frame");
  a_width_hold: assert property (|ioOe && |$past(ioOe) |->
    $stable(ioOe))
    else $error("driven width changed within a frame");
  a_drive_fall: assert property ($changed(ioOut) && |ioOe |->
    !sclkPin)
    else $error("data changed while serial clock high");
  c_cont: cover property ($rose(contReadActive));
  c_quad: cover property (ioOe == 4'hf);
  c_dual: cover property (ioOe == 4'h3);
endmodule : sfmr_core_props

bind sfmr_read_core sfmr_core_props sfmr_core_props_inst (
  .core_clk(core_clk), .rst_n(rst_n), .csPin_n(csPin_n),
  .sclkPin(sclkPin), .ioOut(ioOut), .ioOe(ioOe),
  .contReadActive(contReadActive), .contReadModeBits(contReadModeBits),
  .readBusy(readBusy));

// ### testbench/sfmr_read_core_test.sv
// Purpose: Self-checking bench of the multi-line flash read core.
// Assumes: Array loaded through the load port before any frame.
// Notes:   Each frame except the two mode-reset frames is one call of rdFrame with expected results.
`timescale 1ns/1ps
module sfmr_read_core_test;
  logic        core_clk, rst_n, ce, quadEnableBit, loadEn;
  logic [20:0] loadAddr;
  logic [7:0]  loadData, contReadModeBits;
  logic        csPin_n, sclkPin, contReadActive, readBusy;
  logic [3:0]  ioIn, ioOut, ioOe;
  int          numErrors, nCompared, cycles;
  sfmr_read_core sfmr_read_core_inst (.core_clk(core_clk), .rst_n(rst_n),
    .ce(ce), .csPin_n(csPin_n), .sclkPin(sclkPin), .ioIn(ioIn),
    .ioOut(ioOut), .ioOe(ioOe), .quadEnableBit(quadEnableBit),
    .contReadActive(contReadActive), .contReadModeBits(contReadModeBits),
    .readBusy(readBusy), .loadEn(loadEn), .loadAddr(loadAddr),
    .loadData(loadData));
  sfmr_spi_host sfmr_spi_host_inst (.core_clk(core_clk), .csPin_n(csPin_n),
    .sclkPin(sclkPin), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pat(input logic [20:0] a);
    return a[7:0] ^ a[20:13] ^ 8'h5a;
  endfunction : pat
  task automatic end_sim();
    $display("errors %0d of %0d compared", numErrors, nCompared);
    if (numErrors == 0 && nCompared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic cmpVal(input logic [7:0] g, input logic [7:0] e);
    nCompared++;
    if (g !== e) begin
      numErrors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmpVal
  // Unused phases take 0; a zero expected output enable (eo) means the frame is refused.
  task automatic rdFrame(input logic [7:0] op, input bit useOp, input int aw,
    input logic [23:0] a, input bit useM, input logic [7:0] m, input int db,
    input int dw, input int n, input int part, input logic [3:0] eo);
    logic [7:0] b;
    logic [3:0] s, oe;
    sfmr_spi_host_inst.csLow();
    if (useOp) sfmr_spi_host_inst.send(1, 8, 32'(op), 1'b0);
    sfmr_spi_host_inst.send(aw, 24, 32'(a), !useM && db == 0);
    if (useM) sfmr_spi_host_inst.send(aw, 8, 32'(m), db == 0);
    if (db > 0) sfmr_spi_host_inst.send(aw, db, 32'h0, 1'b1);
    for (int i = 0; i < n; i++) begin
      sfmr_spi_host_inst.recv(dw, b, oe);
      if (eo != 4'h0) cmpVal(b, pat(a[20:0] + 21'(i)));
      cmpVal({4'h0, oe}, {4'h0, eo});
    end
    for (int i = 0; i < part; i++) sfmr_spi_host_inst.tick(4'h0, 1'b0,
      1'b0, s, oe);
    sfmr_spi_host_inst.csHigh();
  endtask : rdFrame
  ////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // A full run needs about 3700 core clocks.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      numErrors++;
      end_sim();
    end
  end
  initial begin
    logic [20:0] la;
    {rst_n, loadEn, loadAddr, loadData} = '0;
    {ce, quadEnableBit} = 2'b11;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    cmpVal({ioOe, 2'b00, contReadActive, readBusy}, 8'h00);
    cmpVal(contReadModeBits, 8'h00);
    for (int k = 0; k < 24; k++) begin
      la = (k < 8) ? 21'(k) : (k < 16) ? 21'h012338 + 21'(k)
         : 21'h1fffe8 + 21'(k);
      @(posedge core_clk);
      loadEn   <= 1'b1;
      loadAddr <= la;
      loadData <= pat(la);
    end
    @(posedge core_clk);
    loadEn <= 1'b0;
    rdFrame(8'h3b, 1, 1, 24'h012340, 0, 8'h00, 8, 2, 4, 0, 4'h3);
    rdFrame(8'h6b, 1, 1, 24'h1ffffe, 0, 8'h00, 8, 4, 3, 0, 4'hf);
    rdFrame(8'hbb, 1, 2, 24'h000002, 1, 8'h2f, 0, 2, 2, 0, 4'h3);
    cmpVal({7'h00, contReadActive}, 8'h01);
    rdFrame(8'h00, 0, 2, 24'h012344, 1, 8'h00, 0, 2, 2, 2, 4'h3);
    cmpVal({4'h0, ioOe}, 8'h00);
    cmpVal({7'h00, contReadActive}, 8'h00);
    rdFrame(8'hbb, 1, 2, 24'h000005, 1, 8'h0f, 0, 2, 1, 0, 4'h3);
    cmpVal(contReadModeBits, 8'h0f);
    // First pass with the clock enable low must leave the mode bits alone.
    ce <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      sfmr_spi_host_inst.csLow();
      sfmr_spi_host_inst.send(1, 8, 32'hff, 1'b1);
      sfmr_spi_host_inst.csHigh();
      cmpVal(contReadModeBits, (p == 0) ? 8'h0f : 8'h00);
      ce <= 1'b1;
    end
    rdFrame(8'heb, 1, 4, 24'h1fffff, 1, 8'ha0, 16, 4, 2, 0, 4'hf);
    cmpVal({7'h00, contReadActive}, 8'h01);
    rdFrame(8'h00, 0, 4, 24'h000004, 1, 8'h00, 16, 4, 1, 0, 4'hf);
    quadEnableBit <= 1'b0;
    rdFrame(8'heb, 1, 4, 24'h000006, 1, 8'h00, 16, 4, 1, 0, 4'h0);
    end_sim();
  end
endmodule : sfmr_read_core_test

// ### testbench/sfmr_spi_host.sv
// Purpose: Behavioural host that drives the serial flash pins.
// Assumes: Serial clock idles low; H core clocks low and H+1 high per period.
// Notes:   Data are sampled late in the high phase, before the fall.
`timescale 1ns/1ps
module sfmr_spi_host #(
  parameter int H = 6
) (
  // Pacing clock.
  input  logic       core_clk,
  // Serial pins.
  output logic       csPin_n,
  output logic       sclkPin,
  output logic [3:0] ioIn,
  input  logic [3:0] ioOut,
  input  logic [3:0] ioOe
);
  logic [3:0] hostIo;
  logic       hostEn;
  // Released lines show the inverse of the last level, never a copy.
  assign ioIn = (ioOe & ioOut) | (~ioOe & (hostEn ? hostIo : ~hostIo));
  initial begin
    csPin_n = 1'b1;
    sclkPin = 1'b0;
    hostIo  = 4'h0;
    hostEn  = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic tick(input logic [3:0] d, input bit en, input bit rel,
                      output logic [3:0] s, output logic [3:0] oe);
    hostEn <= en;
    if (en) hostIo <= d;
    repeat (H) @(posedge core_clk);
    sclkPin <= 1'b1;
    repeat (H) @(posedge core_clk);
    s  = ioOut;
    oe = ioOe;
    if (rel) hostEn <= 1'b0;
    @(posedge core_clk);
    sclkPin <= 1'b0;
  endtask : tick
  task automatic send(input int lines, input int nb, input logic [31:0] v,
                      input bit rel);
    logic [31:0] x;
    logic [3:0]  s, oe;
    x = v << (32 - nb);
    for (int c = 0; c < nb / lines; c++) begin
      tick(x[31:28] >> (4 - lines), 1'b1, rel && c == nb / lines - 1, s, oe);
      x = x << lines;
    end
  endtask : send
  task automatic recv(input int lines, output logic [7:0] b,
                      output logic [3:0] oe);
    logic [3:0] s;
    b = 8'h00;
    for (int c = 0; c < 8 / lines; c++) begin
      tick(4'h0, 1'b0, 1'b0, s, oe);
      b = (b << lines) | 8'(s & ((4'h1 << lines) - 4'h1));
    end
  endtask : recv
  task automatic csLow();
    csPin_n <= 1'b0;
    hostEn  <= 1'b1;
    repeat (H) @(posedge core_clk);
  endtask : csLow
  task automatic csHigh();
    repeat (H) @(posedge core_clk);
    csPin_n <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask : csHigh
endmodule : sfmr_spi_host
